// file: mdf_pkg.sv
// Constants and types for the modem deviation and channel filter config.
// Assumes an APB master with 32-bit data; registers sit in the low byte.
// Summary of operation
// - Deviation bit 7 set enables Gaussian shaping of transmitted data.
// - Tx deviation is Fref times mantissa times 2^(exponent-16 or -15).
// - Zero tx mantissa selects on-off keying in receive and transmit.
// - Settle field: 0 off, 1/2/3 average over 1/2/4 bit pairs.
// - Rx deviation is baud times mantissa times 2^(exponent-3) over 3.
// - Decimator input is left-shifted by the decimator_input_shift field.
// - Decimation divisor is code plus one; bandwidth 307.2 kHz over it.
// - Baud rate is the baud-base modem clock divided by eight.
package mdf_pkg;
  // Register indices; each byte address is four times its index.
  localparam logic [9:0]  TX_DEV_IDX   = 10'h00E;
  localparam logic [9:0]  AFC_RX_IDX   = 10'h00F;
  localparam logic [9:0]  FILTER_IDX   = 10'h010;
  localparam logic [11:0] TX_DEV_OFS   = {TX_DEV_IDX, 2'b00};
  localparam logic [11:0] AFC_RX_OFS   = {AFC_RX_IDX, 2'b00};
  localparam logic [11:0] FILTER_OFS   = {FILTER_IDX, 2'b00};
  localparam logic [7:0]  TX_DEV_RST   = 8'hE8;
  localparam logic [7:0]  AFC_RX_RST   = 8'h9C;
  localparam logic [7:0]  FILTER_RST   = 8'h00;
  localparam logic [7:0]  FILTER_WMASK = 8'hE7;
  localparam int          TX_SHAPE_BIT = 7;
  localparam int          FILT_SKIP_BIT = 7;
  localparam logic [4:0]  TX_LO_BIAS   = 5'h10;
  localparam logic [4:0]  TX_HI_BIAS   = 5'h0F;
  localparam logic [1:0]  RX_BIAS      = 2'h3;
  localparam int          BAUD_DIV     = 8;
  localparam int          BAUD_DIV_W   = 3;
  localparam logic [11:0] APB_AMASK    = 12'hFFF;

  typedef struct packed {
    logic       shape_en;
    logic [2:0] exponent;
    logic [3:0] mantissa;
  } mdf_tx_dev_t;

  typedef struct packed {
    logic [1:0] settle_sel;
    logic [1:0] exponent;
    logic [3:0] mantissa;
  } mdf_afc_t;

  typedef struct packed {
    logic       analog_skip;
    logic [1:0] decimator_input_shift;
    logic [1:0] rsvd;
    logic [2:0] decimation_divisor;
  } mdf_filter_t;

  typedef enum logic [1:0] {
    MDF_AFC_OFF = 2'b00,
    MDF_AFC_1   = 2'b01,
    MDF_AFC_2   = 2'b10,
    MDF_AFC_4   = 2'b11
  } mdf_settle_t;
endpackage

// file: mdf_baud_div.sv
// Baud tick generator: divides the modem clock enable by eight.
// Assumes MODEM_TICK is a one-cycle enable on the same clock.
`timescale 1ns/1ps
module mdf_baud_div
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Modem clock enable in, baud enable out
  input  wire logic modem_tick,
  output logic      baud_tick
);
  logic [mdf_pkg::BAUD_DIV_W-1:0] cnt_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r     <= '0;
      baud_tick <= 1'b0;
    end
    else if (ce)
    begin
      baud_tick <= 1'b0;
      if (modem_tick)
      begin
        cnt_r <= cnt_r + 3'h1;
        baud_tick <= (cnt_r == 3'(mdf_pkg::BAUD_DIV - 1));
      end
    end
  end
endmodule

// file: mdf_top.sv
// Register bank for the modem deviation, AFC and channel filter settings.
// Assumes an APB master on MCLK and synchronous upstream sample strobes.
`timescale 1ns/1ps
module mdf_top
(
  // Clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        CLK_EN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // Modem timing and data path
  input  wire logic        MODEM_TICK,
  input  wire logic        HIGH_BAND,
  input  wire logic [7:0]  DEC_SAMPLE,
  // Decoded settings, shifted decimator sample and baud tick
  output logic             GAUSS_EN,
  output logic             OOK_EN,
  output logic [4:0]       TX_DEV_SHIFT,
  output logic [3:0]       TX_DEV_MANT,
  output logic [2:0]       AFC_AVG_PAIRS,
  output logic             AFC_EN,
  output logic [1:0]       RX_DEV_SHIFT,
  output logic [3:0]       RX_DEV_MANT,
  output logic             ANALOG_SKIP,
  output logic [10:0]      DEC_SHIFTED,
  output logic [3:0]       DEC_DIVISOR,
  output logic             BAUD_TICK
);
  mdf_pkg::mdf_tx_dev_t tx_r;
  mdf_pkg::mdf_afc_t    afc_r;
  mdf_pkg::mdf_filter_t filt_r;
  logic                 setup;
  logic                 wr_en;
  logic [7:0]           rd_nxt;
  logic                 hit;

  // Averaging depth in bit pairs for a settle code; zero means off.
  function automatic logic [2:0] pairs_of(input logic [1:0] code);
    case (mdf_pkg::mdf_settle_t'(code))
      mdf_pkg::MDF_AFC_1: pairs_of = 3'h1;
      mdf_pkg::MDF_AFC_2: pairs_of = 3'h2;
      mdf_pkg::MDF_AFC_4: pairs_of = 3'h4;
      default:            pairs_of = 3'h0;
    endcase
  endfunction

  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE && PREADY;

  always_comb
  begin
    hit    = 1'b1;
    rd_nxt = 8'h00;
    case (PADDR & mdf_pkg::APB_AMASK)
      mdf_pkg::TX_DEV_OFS: rd_nxt = tx_r;
      mdf_pkg::AFC_RX_OFS: rd_nxt = afc_r;
      mdf_pkg::FILTER_OFS: rd_nxt = filt_r & mdf_pkg::FILTER_WMASK;
      default:             hit = 1'b0;
    endcase
  end

  // No wait states: PREADY rises in the first access cycle.
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (CLK_EN)
    begin
      PREADY  <= setup;
      PSLVERR <= setup && !hit;
      if (setup && !PWRITE)
        PRDATA <= {24'h00_0000, rd_nxt};
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      tx_r   <= mdf_pkg::TX_DEV_RST;
      afc_r  <= mdf_pkg::AFC_RX_RST;
      filt_r <= mdf_pkg::FILTER_RST;
    end
    else if (CLK_EN && wr_en)
    begin
      case (PADDR & mdf_pkg::APB_AMASK)
        mdf_pkg::TX_DEV_OFS: tx_r  <= PWDATA[7:0];
        mdf_pkg::AFC_RX_OFS: afc_r <= PWDATA[7:0];
        mdf_pkg::FILTER_OFS: filt_r <= PWDATA[7:0] & mdf_pkg::FILTER_WMASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      GAUSS_EN      <= 1'b1;
      OOK_EN        <= 1'b0;
      TX_DEV_SHIFT  <= 5'h0A;
      TX_DEV_MANT   <= 4'h8;
      AFC_AVG_PAIRS <= 3'h2;
      AFC_EN        <= 1'b1;
      RX_DEV_SHIFT  <= 2'h2;
      RX_DEV_MANT   <= 4'hC;
      ANALOG_SKIP   <= 1'b0;
      DEC_DIVISOR   <= 4'h1;
    end
    else if (CLK_EN)
    begin
      GAUSS_EN     <= tx_r.shape_en;
      OOK_EN       <= (tx_r.mantissa == 4'h0);
      // Right-shift amount applied to Fref*mantissa.
      TX_DEV_SHIFT <= (HIGH_BAND ? mdf_pkg::TX_HI_BIAS
                                 : mdf_pkg::TX_LO_BIAS)
                      - {2'b00, tx_r.exponent};
      TX_DEV_MANT  <= tx_r.mantissa;
      AFC_AVG_PAIRS <= pairs_of(afc_r.settle_sel);
      AFC_EN       <= (afc_r.settle_sel != 2'b00);
      RX_DEV_SHIFT <= mdf_pkg::RX_BIAS - afc_r.exponent;
      RX_DEV_MANT  <= afc_r.mantissa;
      ANALOG_SKIP  <= filt_r.analog_skip;
      DEC_DIVISOR  <= {1'b0, filt_r.decimation_divisor} + 4'h1;
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      DEC_SHIFTED <= 11'h000;
    else if (CLK_EN)
      DEC_SHIFTED <= {3'b000, DEC_SAMPLE} << filt_r.decimator_input_shift;
  end

  mdf_baud_div u_baud
  (
    .clk        (MCLK),
    .rst        (RESET),
    .ce         (CLK_EN),
    .modem_tick (MODEM_TICK),
    .baud_tick  (BAUD_TICK)
  );

  // Steps of one APB transfer, shared by the bus checks below.
  sequence s_apb_setup;
    CLK_EN && PSEL && !PENABLE;
  endsequence

  sequence s_apb_access;
    CLK_EN && PSEL && PENABLE && PREADY;
  endsequence

  sequence s_filter_write;
    s_apb_access ##0
      PWRITE && (PADDR & mdf_pkg::APB_AMASK) == mdf_pkg::FILTER_OFS;
  endsequence

  chk_apb_ready: assert property (@(posedge MCLK) disable iff (RESET)
    s_apb_setup |=> PREADY)
    else $error("Ready missing in the first access cycle");

  chk_ready_pulse: assert property (@(posedge MCLK) disable iff (RESET)
    s_apb_access |=> !PREADY)
    else $error("Ready held for more than one cycle");

  chk_slverr_map: assert property (@(posedge MCLK) disable iff (RESET)
    s_apb_setup |=> PSLVERR == !$past(hit))
    else $error("Slave error does not match the address decode");

  chk_read_data: assert property (@(posedge MCLK) disable iff (RESET)
    s_apb_setup ##0 !PWRITE |=> PRDATA == {24'h00_0000, $past(rd_nxt)})
    else $error("Read data does not match the addressed register");

  chk_filter_write: assert property (
    @(posedge MCLK) disable iff (RESET)
    s_filter_write |=> filt_r == ($past(PWDATA[7:0]) & mdf_pkg::FILTER_WMASK))
    else $error("Filter write does not drop the reserved bits");

  chk_ook_select: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN |=> OOK_EN == ($past(tx_r.mantissa) == 4'h0))
    else $error("OOK select does not follow tx mantissa");

  chk_gauss_follow: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN |=> GAUSS_EN == $past(tx_r[7]))
    else $error("Gaussian enable does not follow bit 7");

  chk_dec_divisor: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN |=> DEC_DIVISOR == {1'b0, $past(filt_r.decimation_divisor)} + 4'h1)
    else $error("Divisor is not code plus one");

  chk_filter_rsvd: assert property (@(posedge MCLK) disable iff (RESET)
    filt_r[4:3] == 2'b00)
    else $error("Reserved filter bits are set");

  chk_afc_pairs: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && afc_r.settle_sel == 2'b11 |=> AFC_AVG_PAIRS == 3'h4)
    else $error("Settle code 3 does not give 4 pairs");

  chk_afc_off: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && afc_r.settle_sel == 2'b00 |=> !AFC_EN)
    else $error("AFC not off for code 0");

  chk_rx_shift: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN |=> RX_DEV_SHIFT == 2'h3 - $past(afc_r.exponent))
    else $error("Rx deviation shift wrong");

  chk_mant_follow: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN |=> RX_DEV_MANT == $past(afc_r.mantissa) &&
      TX_DEV_MANT == $past(tx_r.mantissa))
    else $error("Deviation mantissa outputs do not follow registers");

  chk_tx_shift: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && HIGH_BAND |=> TX_DEV_SHIFT == 5'h0F - $past(tx_r.exponent))
    else $error("High band tx shift wrong");

  chk_tx_lo_shift: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && !HIGH_BAND |=> TX_DEV_SHIFT == 5'h10 - $past(tx_r.exponent))
    else $error("Low band tx shift wrong");

  chk_decimator_input_shift: assert property (@(posedge MCLK) disable iff (RESET)
    CLK_EN && filt_r.decimator_input_shift == 2'h1 |=>
      DEC_SHIFTED == {2'b00, $past(DEC_SAMPLE), 1'b0})
    else $error("Decimator shift wrong");

  chk_reset_vals: assert property (@(posedge MCLK)
    $fell(RESET) |-> tx_r == 8'hE8 && afc_r == 8'h9C)
    else $error("Register defaults not loaded");
endmodule

// file: tb_modem_deviation_filter_config.sv
// Self-checking bench for the modem deviation and channel filter bank.
// Assumes mdf_pkg and mdf_top are compiled first; APB on a 100 MHz MCLK.
`timescale 1ns/1ps
module tb_modem_deviation_filter_config;
  typedef struct {logic [11:0] a; logic [31:0] d; logic h; logic [7:0] s;}
    mdf_row_t;
  logic        mclk, reset, clk_en, psel, penable, pwrite, pready, pslverr;
  logic        modem_tick, high_band, gauss_en, ook_en, afc_en, skip, baud;
  logic        er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  dec_sample, tx_s, afc_s, flt_s;
  logic [4:0]  tx_shift;
  logic [3:0]  tx_mant, rx_mant, decimation_divisor;
  logic [2:0]  pairs;
  logic [1:0]  rx_shift;
  logic [10:0] dec_sh;
  int          n_fail, num_checks, nb;
  mdf_row_t    rows[9] = '{
    '{12'h038, 32'hFFFFFF80, 1'b0, 8'h81},
    '{12'h038, 32'h7F, 1'b1, 8'h81},
    '{12'h03C, 32'h08, 1'b1, 8'hC3},
    '{12'h03C, 32'h5B, 1'b0, 8'hC3},
    '{12'h03C, 32'hAF, 1'b0, 8'h7E},
    '{12'h03C, 32'hF8, 1'b0, 8'h7E},
    '{12'h040, 32'hBF, 1'b0, 8'hFF},
    '{12'h040, 32'h01, 1'b1, 8'h80},
    '{12'h040, 32'h3A, 1'b0, 8'hA5}};

  mdf_top u_dut (
    .MCLK(mclk), .RESET(reset), .CLK_EN(clk_en), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .MODEM_TICK(modem_tick), .HIGH_BAND(high_band), .DEC_SAMPLE(dec_sample),
    .GAUSS_EN(gauss_en), .OOK_EN(ook_en), .TX_DEV_SHIFT(tx_shift),
    .TX_DEV_MANT(tx_mant), .AFC_AVG_PAIRS(pairs), .AFC_EN(afc_en),
    .RX_DEV_SHIFT(rx_shift), .RX_DEV_MANT(rx_mant), .ANALOG_SKIP(skip),
    .DEC_SHIFTED(dec_sh), .DEC_DIVISOR(decimation_divisor), .BAUD_TICK(baud));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request is held until the edge at which pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int t;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge mclk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    chk("pready", pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Readback, then every decoded output against the shadow copies.
  task automatic check_all;
    apb(1'b0, 12'h038, 32'h0);
    chk("tx_rd", rd, {24'h0, tx_s});
    apb(1'b0, 12'h03C, 32'h0);
    chk("afc_rd", rd, {24'h0, afc_s});
    apb(1'b0, 12'h040, 32'h0);
    chk("flt_rd", rd, {24'h0, flt_s});
    @(posedge mclk);
    chk("gauss", gauss_en, tx_s[7]);
    chk("tx_shift", tx_shift, (high_band ? 15 : 16) - tx_s[6:4]);
    chk("tx_mant", tx_mant, tx_s[3:0]);
    chk("ook", ook_en, tx_s[3:0] == 4'h0);
    chk("pairs", pairs, (afc_s[7:6] == 2'h3) ? 4 : afc_s[7:6]);
    chk("afc_en", afc_en, afc_s[7:6] != 2'h0);
    chk("rx_shift", rx_shift, 3 - afc_s[5:4]);
    chk("rx_mant", rx_mant, afc_s[3:0]);
    chk("skip", skip, flt_s[7]);
    chk("dec_sh", dec_sh, {3'h0, dec_sample} << flt_s[6:5]);
    chk("decimation_divisor", decimation_divisor, flt_s[2:0] + 1);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    repeat (4000) @(posedge mclk);
    n_fail++;
    end_of_test;
  end

  initial
  begin
    {reset, clk_en, psel, penable, pwrite, modem_tick, high_band} = 7'h60;
    paddr = 12'h0;
    pwdata = 32'h0;
    dec_sample = 8'h81;
    {tx_s, afc_s, flt_s} = 24'hE89C00;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    check_all;
    foreach (rows[k])
    begin
      high_band <= rows[k].h;
      dec_sample <= rows[k].s;
      apb(1'b1, rows[k].a, rows[k].d);
      chk("err", er, 1'b0);
      case (rows[k].a)
        12'h038: tx_s = rows[k].d[7:0];
        12'h03C: afc_s = rows[k].d[7:0];
        default: flt_s = rows[k].d[7:0] & 8'hE7;
      endcase
      check_all;
    end
    apb(1'b1, 12'h044, 32'hFF);
    chk("err_w", er, 1'b1);
    apb(1'b0, 12'h044, 32'h0);
    chk("err_r", er, 1'b1);
    chk("rd_bad", rd, 32'h0);
    check_all;
    // 64 modem ticks give eight baud ticks; frozen clock gives none.
    nb = 0;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge mclk);
      modem_tick <= (i < 64 || i >= 72);
      clk_en <= (i < 72);
      @(negedge mclk);
      nb += int'(baud === 1'b1);
      if (i == 71)
        chk("baud", nb, 8);
    end
    chk("baud_frz", nb, 8);
    @(posedge mclk);
    clk_en <= 1'b1;
    modem_tick <= 1'b0;
    reset <= 1'b1;
    @(negedge mclk);
    chk("rst_rdy", pready, 1'b0);
    chk("rst_gauss", gauss_en, 1'b1);
    @(posedge mclk);
    reset <= 1'b0;
    {tx_s, afc_s, flt_s} = 24'hE89C00;
    check_all;
    end_of_test;
  end
endmodule
